// file: rtl/paired_timer_cfg.svh
// register offsets, field positions, masks and timing counts for the paired timer
`ifndef PAIRED_TIMER_CFG_SVH
`define PAIRED_TIMER_CFG_SVH

// ====================================================================
// register byte offsets
`define OFS_LOWER_CTL 8'h00
`define OFS_UPPER_CTL 8'h04
`define OFS_LOWER_CNT 8'h08
`define OFS_UPPER_CNT 8'h0C
`define OFS_LOWER_PER 8'h10
`define OFS_UPPER_PER 8'h14
`define OFS_IRQ_STS 8'h18
`define OFS_IRQ_MASK 8'h1C

// ====================================================================
// control field positions
`define BIT_RUN_ENABLE 15
`define BIT_IDLE_HALT 13
`define BIT_GATED_ACC 6
`define BIT_PRESCALE_HI 5
`define BIT_PRESCALE_LO 4
`define BIT_PAIR_JOIN 3
`define BIT_CLK_SOURCE 1

// implemented control bits; everything else reads zero
`define LOWER_CTL_MASK 16'hA07A
`define UPPER_CTL_MASK 16'hA072

// ====================================================================
// reset values
`define CTL_RESET 16'h0000
`define CNT_RESET 16'h0000
`define PER_RESET 16'hFFFF
`define IRQ_RESET 2'h0

// ====================================================================
// status bits
`define STS_LOWER_MATCH 0
`define STS_UPPER_MATCH 1

// ====================================================================
// prescaler terminal counts (ratio minus one)
`define PRESCALE_LIM_1 8'h00
`define PRESCALE_LIM_8 8'h07
`define PRESCALE_LIM_64 8'h3F
`define PRESCALE_LIM_256 8'hFF

// ====================================================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/paired_timer_pkg.sv
// types shared by the paired timer
package paired_timer_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic [1:0] {
    PRESCALE_1 = 2'h0,
    PRESCALE_8 = 2'h1,
    PRESCALE_64 = 2'h2,
    PRESCALE_256 = 2'h3
  } prescale_t;

endpackage : paired_timer_pkg

// file: rtl/paired_timer.sv
// paired 16/32-bit timer with an AXI4-Lite register slave
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`include "paired_timer_cfg.svh"

module paired_timer
  import paired_timer_pkg::*;
#(
  parameter bit HAS_TRIGGER = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // device state and pins
  input wire logic idle_i,
  input wire logic lower_ext_clock_pin_i,
  input wire logic upper_ext_clock_pin_i,
  input wire logic lower_gate_pin_i,
  input wire logic upper_gate_pin_i,
  // events
  output logic irq_o,
  output logic event_trigger_o
);

  // ==================================================================
  // storage
  word_t ctl_q [2];
  logic [1:0][15:0] cnt_q;
  logic [1:0][15:0] cnt_d;
  logic [1:0][15:0] per_q;
  logic [7:0] pre_q [2];
  logic [1:0] sts_q;
  logic [1:0] sts_d;
  logic [1:0] mask_q;
  logic [1:0] hit;
  logic [1:0] clk_s1_q, clk_s2_q, clk_s3_q;
  logic [1:0] gate_s1_q, gate_s2_q;
  logic irq_q, trig_q;

  // axi state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  function automatic word_t merge(input word_t old, input logic [31:0] d,
                                  input logic [3:0] s);
    word_t r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge

  // ==================================================================
  // bus decode
  wire aw_go = s_axi_awvalid_i & awready_q;
  wire w_go = s_axi_wvalid_i & wready_q;
  wire wr_do = aw_full_q & w_full_q & ~bvalid_q;
  wire b_done = bvalid_q & s_axi_bready_i;
  wire ar_go = s_axi_arvalid_i & arready_q;
  wire r_done = rvalid_q & s_axi_rready_i;

  wire wr_lctl = wr_do & (aw_addr_q == `OFS_LOWER_CTL);
  wire wr_uctl = wr_do & (aw_addr_q == `OFS_UPPER_CTL);
  wire wr_lcnt = wr_do & (aw_addr_q == `OFS_LOWER_CNT);
  wire wr_ucnt = wr_do & (aw_addr_q == `OFS_UPPER_CNT);
  wire wr_lper = wr_do & (aw_addr_q == `OFS_LOWER_PER);
  wire wr_uper = wr_do & (aw_addr_q == `OFS_UPPER_PER);
  wire wr_sts = wr_do & (aw_addr_q == `OFS_IRQ_STS);
  wire wr_mask = wr_do & (aw_addr_q == `OFS_IRQ_MASK);
  wire wr_hit = wr_lctl | wr_uctl | wr_lcnt | wr_ucnt | wr_lper | wr_uper | wr_sts | wr_mask;
  wire [1:0] wr_cnt = {wr_ucnt, wr_lcnt};
  wire [1:0] wr_ctl = {wr_uctl, wr_lctl};

  // read data is captured at the address handshake, not when rready comes
  wire [31:0] rd_word =
    (s_axi_araddr_i == `OFS_LOWER_CTL) ? {16'h0000, ctl_q[0]} :
    (s_axi_araddr_i == `OFS_UPPER_CTL) ? {16'h0000, ctl_q[1]} :
    (s_axi_araddr_i == `OFS_LOWER_CNT) ? {16'h0000, cnt_q[0]} :
    (s_axi_araddr_i == `OFS_UPPER_CNT) ? {16'h0000, cnt_q[1]} :
    (s_axi_araddr_i == `OFS_LOWER_PER) ? {16'h0000, per_q[0]} :
    (s_axi_araddr_i == `OFS_UPPER_PER) ? {16'h0000, per_q[1]} :
    (s_axi_araddr_i == `OFS_IRQ_STS) ? {30'h0, sts_q} :
    (s_axi_araddr_i == `OFS_IRQ_MASK) ? {30'h0, mask_q} : 32'h0000_0000;
  // anything past the mask register or off a word boundary answers slverr
  wire rd_hit = (s_axi_araddr_i[1:0] == 2'h0) & (s_axi_araddr_i <= `OFS_IRQ_MASK);

  // ==================================================================
  // timer configuration
  // joining parks the upper prescaler, so it restarts cleanly on unjoin
  wire joined = ctl_q[0][`BIT_PAIR_JOIN];
  logic [1:0] run, src_tick, tick;
  logic [7:0] lim [2];

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    wire word_t c = ctl_q[i];
    wire prescale_t ps = prescale_t'(c[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO]);
    // a pin must stay high and low one clock each or its edge is lost
    wire ext_edge = clk_s2_q[i] & ~clk_s3_q[i];
    wire halted = c[`BIT_IDLE_HALT] & idle_i;
    // upper timer is idle while joined: lower control drives the pair
    if (i == 0) begin : g_lo
      assign run[i] = c[`BIT_RUN_ENABLE] & ~halted;
    end else begin : g_up
      assign run[i] = c[`BIT_RUN_ENABLE] & ~halted & ~joined;
    end
    // gate only applies to the internal clock
    assign src_tick[i] = c[`BIT_CLK_SOURCE] ? ext_edge :
                         (~c[`BIT_GATED_ACC] | gate_s2_q[i]);
    always_comb begin
      unique case (ps)
        PRESCALE_1: lim[i] = `PRESCALE_LIM_1;
        PRESCALE_8: lim[i] = `PRESCALE_LIM_8;
        PRESCALE_64: lim[i] = `PRESCALE_LIM_64;
        PRESCALE_256: lim[i] = `PRESCALE_LIM_256;
      endcase
    end
    assign tick[i] = run[i] & src_tick[i] & (pre_q[i] == lim[i]);

    // stopping clears the prescaler too, so a restart begins a full division
    always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
        pre_q[i] <= 8'h00;
      end else if (wr_ctl[i] || !run[i]) begin
        pre_q[i] <= 8'h00;
      end else if (src_tick[i]) begin
        pre_q[i] <= (pre_q[i] == lim[i]) ? 8'h00 : pre_q[i] + 8'h01;
      end
    end
  end

  // ==================================================================
  // counting
  always_comb begin
    cnt_d = cnt_q;
    hit = 2'b00;
    // a count written above the period runs on to the wrap before it matches
    if (joined) begin
      if (tick[0]) begin
        if (cnt_q == per_q) begin
          cnt_d = 32'h0000_0000;
          hit[`STS_UPPER_MATCH] = 1'b1;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tick[i]) begin
          if (cnt_q[i] == per_q[i]) begin
            cnt_d[i] = 16'h0000;
            hit[i] = 1'b1;
          end else begin
            cnt_d[i] = cnt_q[i] + 16'h0001;
          end
        end
      end
    end
    // a software write to a count word overrides the tick
    for (int i = 0; i < 2; i++) begin
      if (wr_cnt[i]) begin
        cnt_d[i] = merge(cnt_q[i], w_data_q, w_strb_q);
      end
    end
  end

  // the status clear ignores strobes: only a written one clears a bit
  // set wins over a one-to-clear in the same cycle
  assign sts_d = (sts_q & ~(wr_sts ? w_data_q[1:0] : 2'b00)) | hit;

  // ==================================================================
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ctl_q[0] <= `CTL_RESET;
      ctl_q[1] <= `CTL_RESET;
      cnt_q <= {`CNT_RESET, `CNT_RESET};
      per_q <= {`PER_RESET, `PER_RESET};
      sts_q <= `IRQ_RESET;
      mask_q <= `IRQ_RESET;
      irq_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      if (wr_lctl) begin
        ctl_q[0] <= merge(ctl_q[0], w_data_q, w_strb_q) & `LOWER_CTL_MASK;
      end
      if (wr_uctl) begin
        ctl_q[1] <= merge(ctl_q[1], w_data_q, w_strb_q) & `UPPER_CTL_MASK;
      end
      if (wr_lper) begin
        per_q[0] <= merge(per_q[0], w_data_q, w_strb_q);
      end
      if (wr_uper) begin
        per_q[1] <= merge(per_q[1], w_data_q, w_strb_q);
      end
      if (wr_mask && w_strb_q[0]) begin
        mask_q <= w_data_q[1:0];
      end
      cnt_q <= cnt_d;
      sts_q <= sts_d;
      // a mask change reaches irq one clock later than a status change
      irq_q <= |(sts_d & mask_q);
      // the trigger follows the upper match in both modes; the second pair ties it low
      trig_q <= HAS_TRIGGER & hit[`STS_UPPER_MATCH];
    end
  end

  // ==================================================================
  // pin synchronisers; stage one feeds only stage two
  // the gate takes the same two stages, so it lags its pin by two clocks
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      clk_s1_q <= 2'b00;
      clk_s2_q <= 2'b00;
      clk_s3_q <= 2'b00;
      gate_s1_q <= 2'b00;
      gate_s2_q <= 2'b00;
    end else begin
      clk_s1_q <= {upper_ext_clock_pin_i, lower_ext_clock_pin_i};
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      gate_s1_q <= {upper_gate_pin_i, lower_gate_pin_i};
      gate_s2_q <= gate_s1_q;
    end
  end

  // ==================================================================
  // axi4-lite handshakes
  // one write and one read at a time; a ready returns only once the answer
  // has been taken, so no skid storage is needed
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (aw_go) begin
        aw_addr_q <= s_axi_awaddr_i;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (w_go) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_do) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_go) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_done) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ==================================================================
  // outputs
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign irq_o = irq_q;
  assign event_trigger_o = trig_q;

endmodule : paired_timer

// file: verification/paired_timer_sva.sv
// port checker for the paired timer
module paired_timer_sva #(
  parameter bit HAS_TRIGGER = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // events
  input wire logic irq_o,
  input wire logic event_trigger_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================
  // assertions
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered");
  a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o
    && s_axi_awready_o) else $error("write answer not retired");
  a_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o
    && s_axi_arready_o) else $error("read answer not retired");
  a_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while answering");
  a_rd_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_trig_owner: assert property (event_trigger_o |-> HAS_TRIGGER)
    else $error("trigger from a pair without one");
  a_reset_clean: assert property (disable iff (1'b0) !resetn_i |=> !irq_o
    && !s_axi_bvalid_o && !event_trigger_o) else $error("outputs active after reset");
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
  c_irq: cover property ($rose(irq_o));
  c_trigger: cover property (event_trigger_o ##2 event_trigger_o);
endmodule : paired_timer_sva

bind paired_timer paired_timer_sva #(.HAS_TRIGGER(HAS_TRIGGER)) chk_u (.*);

// file: verification/paired_16_32_bit_timer_tb_top.sv
// self-checking bench for the paired timer
module paired_16_32_bit_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, idle_i = 1'b0;
  logic lower_ext_clock_pin_i = 1'b0, upper_ext_clock_pin_i = 1'b0;
  logic lower_gate_pin_i = 1'b0, upper_gate_pin_i = 1'b0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic irq_o, event_trigger_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [31:0] s_axi_rdata_o, rv;
  int errors = 0, num_checks = 0, n = 0;

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  paired_timer #(.HAS_TRIGGER(1'b1)) dut_u (.*);

  // ====================================
  // helpers
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // one access; an extra edge at the end keeps back-to-back calls from re-driving in one step
  task automatic bus(input bit w, input logic [7:0] a, input logic [15:0] d);
    bit g, h, e;
    s_axi_awaddr_i <= a;
    s_axi_araddr_i <= a;
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_awvalid_i <= w;
    s_axi_wvalid_i <= w;
    s_axi_bready_i <= w;
    s_axi_arvalid_i <= !w;
    s_axi_rready_i <= !w;
    repeat (40) begin
      @(negedge sys_clk_i);
      g = w ? s_axi_awready_o : s_axi_arready_o;
      h = s_axi_wready_o;
      e = w ? s_axi_bvalid_o : s_axi_rvalid_o;
      rs = w ? s_axi_bresp_o : s_axi_rresp_o;
      rv = s_axi_rdata_o;
      @(posedge sys_clk_i);
      if (g) s_axi_awvalid_i <= 1'b0;
      if (g) s_axi_arvalid_i <= 1'b0;
      if (h) s_axi_wvalid_i <= 1'b0;
      if (e) begin
        s_axi_bready_i <= 1'b0;
        s_axi_rready_i <= 1'b0;
        @(posedge sys_clk_i);
        return;
      end
    end
    errors++;
    close_out();
  endtask : bus

  task automatic stp;
    @(negedge sys_clk_i);
    if (event_trigger_o) n++;
    @(posedge sys_clk_i);
  endtask : stp

  task automatic cnt(input int c);
    repeat (6) stp();
    n = 0;
    repeat (c) stp();
  endtask : cnt

  // cycles between two trigger pulses
  task automatic gap;
    int k;
    k = 0;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (!event_trigger_o && k < 2000);
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (!event_trigger_o && n < 2000);
    @(posedge sys_clk_i);
    if (n < 2000 && k < 2000) return;
    errors++;
    close_out();
  endtask : gap

  task automatic chk_irq(input logic e);
    @(negedge sys_clk_i);
    cmp("irq", e, irq_o);
    @(posedge sys_clk_i);
  endtask : chk_irq

  // k rising edges on the lower clock pin, six clocks apart
  task automatic lower_edges(input int k);
    repeat (k) begin
      lower_ext_clock_pin_i <= 1'b1;
      repeat (3) stp();
      lower_ext_clock_pin_i <= 1'b0;
      repeat (3) stp();
    end
  endtask : lower_edges

  // ====================================
  // scenarios
  task automatic t_regs;
    bus(1'b0, 8'h00, 16'h0000);
    cmp("lower ctl", 32'h0, rv);
    bus(1'b0, 8'h04, 16'h0000);
    cmp("upper ctl", 32'h0, rv);
    bus(1'b1, 8'h00, 16'hFFFF);
    bus(1'b1, 8'h04, 16'hFFFF);
    bus(1'b0, 8'h00, 16'h0000);
    cmp("lower ctl", 32'hA07A, rv);
    bus(1'b0, 8'h04, 16'h0000);
    cmp("upper ctl", 32'hA072, rv);
    bus(1'b1, 8'h00, 16'h0000);
    bus(1'b1, 8'h20, 16'h0001);
    cmp("unmapped", 2'h2, rs);
    bus(1'b0, 8'h20, 16'h0000);
    cmp("unmapped read resp", 2'h2, rs);
    cmp("unmapped read data", 32'h0, rv);
    $display("regs test done");
  endtask : t_regs

  task automatic t_prescale;
    int r[4] = '{1, 8, 64, 256};
    bus(1'b1, 8'h14, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h04, {8'h80, 2'h0, 2'(i), 4'h0});
      gap();
      cmp("period", 32'(2 * r[i]), n);
    end
    $display("prescale test done");
  endtask : t_prescale

  // upper control asks 1:256 but must be ignored while joined
  task automatic t_join;
    bus(1'b1, 8'h10, 16'h0001);
    bus(1'b1, 8'h14, 16'h0000);
    bus(1'b1, 8'h04, 16'h8030);
    bus(1'b1, 8'h00, 16'h8008);
    gap();
    cmp("joined period", 32'h2, n);
    bus(1'b1, 8'h1C, 16'h0002);
    chk_irq(1'b1);
    bus(1'b1, 8'h1C, 16'h0000);
    chk_irq(1'b0);
    bus(1'b1, 8'h00, 16'h0000);
    bus(1'b1, 8'h04, 16'h0000);
    bus(1'b1, 8'h1C, 16'h0002);
    chk_irq(1'b1);
    bus(1'b1, 8'h18, 16'h0003);
    chk_irq(1'b0);
    $display("join test done");
  endtask : t_join

  task automatic t_idle_gate;
    bus(1'b1, 8'h14, 16'h0001);
    bus(1'b1, 8'h04, 16'hA000);
    idle_i <= 1'b1;
    cnt(40);
    cmp("idle halted", 32'h0, n);
    bus(1'b1, 8'h04, 16'h8000);
    cnt(40);
    cmp("idle running", 32'h14, n);
    idle_i <= 1'b0;
    bus(1'b1, 8'h04, 16'h8040);
    cnt(40);
    cmp("gate low", 32'h0, n);
    upper_gate_pin_i <= 1'b1;
    cnt(40);
    cmp("gate high", 32'h14, n);
    $display("idle gate test done");
  endtask : t_idle_gate

  // gate held low: the gate bit must not block an external clock
  task automatic t_ext;
    upper_gate_pin_i <= 1'b0;
    bus(1'b1, 8'h04, 16'h8042);
    cnt(0);
    repeat (8) begin
      upper_ext_clock_pin_i <= 1'b1;
      repeat (3) stp();
      upper_ext_clock_pin_i <= 1'b0;
      repeat (3) stp();
    end
    repeat (6) stp();
    cmp("pin edges", 32'h4, n);
    $display("ext clock test done");
  endtask : t_ext

  // lower timer alone on its pin, then joined with the upper word above it
  task automatic t_lower;
    bus(1'b1, 8'h18, 16'h0003);
    bus(1'b1, 8'h10, 16'h0003);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h00, 16'h8002);
    lower_edges(5);
    bus(1'b0, 8'h08, 16'h0000);
    cmp("lower count", 32'h1, rv);
    bus(1'b0, 8'h18, 16'h0000);
    cmp("lower match", 32'h1, rv);
    bus(1'b1, 8'h00, 16'h0000);
    bus(1'b1, 8'h0C, 16'h0000);
    bus(1'b1, 8'h08, 16'hFFFE);
    bus(1'b1, 8'h18, 16'h0003);
    bus(1'b1, 8'h00, 16'h800A);
    lower_edges(3);
    bus(1'b0, 8'h0C, 16'h0000);
    cmp("upper count word", 32'h1, rv);
    bus(1'b0, 8'h08, 16'h0000);
    cmp("lower count word", 32'h1, rv);
    lower_edges(3);
    bus(1'b0, 8'h18, 16'h0000);
    cmp("joined match", 32'h2, rv);
    bus(1'b0, 8'h08, 16'h0000);
    cmp("joined wrap", 32'h0, rv);
    $display("lower test done");
  endtask : t_lower

  // rewriting the control word keeps clearing the 1:256 prescaler
  task automatic t_rewrite;
    bus(1'b1, 8'h00, 16'h0000);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h00, 16'h8030);
    repeat (200) stp();
    bus(1'b1, 8'h00, 16'h8030);
    repeat (200) stp();
    bus(1'b0, 8'h08, 16'h0000);
    cmp("rewritten prescaler", 32'h0, rv);
    repeat (100) stp();
    bus(1'b0, 8'h08, 16'h0000);
    cmp("prescaler free", 32'h1, rv);
    $display("rewrite test done");
  endtask : t_rewrite

  initial begin
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    t_regs();
    t_prescale();
    t_join();
    t_idle_gate();
    t_ext();
    t_lower();
    t_rewrite();
    close_out();
  end
endmodule : paired_16_32_bit_timer_tb_top
